//--- logic/drm_pkg.sv
// Purpose: Shared constants for the DRAM row/column address multiplexer
// Assumes: 32-bit bank port, single system clock
// Notes:   Register offsets are word indices on the plain register port
package drm_pkg;
    // Internal page size codes
    localparam logic [1:0] PAGE_512  = 2'h0;
    localparam logic [1:0] PAGE_1K   = 2'h1;
    localparam logic [1:0] PAGE_2K   = 2'h2;
    // Register offsets
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_MASK  = 4'h1;
    localparam logic [3:0] OFS_BASE  = 4'h2;
    localparam logic [3:0] OFS_STAT  = 4'h3;
    // Control register fields
    localparam int         CTRL_PS_LSB  = 0;
    localparam int         CTRL_EN_BIT  = 2;
    localparam int         CTRL_PW_LSB  = 3;
    // Reset values
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    // Bank select compares this bit and the bits above it
    localparam int          BANK_LSB = 17;
    // Cycles from row strobe to column mapping
    localparam int          ROW_CYCLES = 1;
    // Transfer sequencing states
    typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_COL} drm_state_t;
endpackage

//--- logic/drm_colmap.sv
// Purpose: Column-phase pin mapping for a 32-bit bank
// Assumes: Pins A[27:9] only; row phase handled by the caller
// Notes:   Pure combinational; output is registered in the top
module drm_colmap (
    input  wire logic [1:0]  page_size,   // Internal page size code
    input  wire logic [31:0] addr,        // Internal address bits
    output logic      [18:0] col_pins     // Column value for A[27:9]
);
    // Index 0 corresponds to pin A[9]
    always_comb
    begin
        col_pins = '0;
        for (int p = 9; p <= 27; p++)
        begin
            // R01 512 byte mapping
            if (page_size == drm_pkg::PAGE_512)
            begin
                if (p <= 15)
                    col_pins[p-9] = addr[p-7];
                else
                    col_pins[p-9] = addr[p & ~1];
            end
            // R02 1 KByte mapping
            else if (page_size == drm_pkg::PAGE_1K)
            begin
                if (p == 9)
                    col_pins[p-9] = addr[9];
                else if (p <= 17)
                    col_pins[p-9] = addr[p-8];
                else
                    col_pins[p-9] = addr[p & ~1];
            end
            // R03 2 KByte mapping
            else
            begin
                if (p == 9)
                    col_pins[p-9] = addr[9];
                else if (p == 10)
                    col_pins[p-9] = addr[10];
                else if (p <= 19)
                    col_pins[p-9] = addr[p-9];
                else
                    col_pins[p-9] = addr[p & ~1];
            end
        end
    end
endmodule

//--- logic/drm_addr_mux.sv
// Purpose: Row/column address multiplexing, page-hit and bank decode
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Internal page size deliberately differs from the DRAM page
//          size; the pin mapping follows the programmed code only
//          A start outside idle updates hit, match and row only; the
//          pins keep serving the transfer in flight
// Function
// R01 - 512 byte column mapping on pins
// R02 - 1 KByte column mapping on pins
// R03 - 2 KByte column mapping on pins
// R04 - Page size from bank control register
// R05 - Hit decided by programmed page size
// R06 - Page offset bits by page size
// R07 - 32-bit bank spans page with 9 pins
// R08 - Mask bits exclude address from bank select
// R09 - Mapping follows programmed page size
// R10 - Software keeps page size, widens mask
// R11 - Hit compares bits above page offset
// R12 - Latch row on first page transfer
// R13 - Row until strobe, column until end
//
// Our own choices: the placing of the registers and strobed register access.
module drm_addr_mux (
    input  wire logic        clk,          // System clock
    input  wire logic        nrst,         // Async reset, active low
    input  wire logic [3:0]  reg_addr,     // Register index
    input  wire logic [31:0] reg_wdata,    // Register write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
    input  wire logic [31:0] xfer_addr,    // Transfer address
    input  wire logic        xfer_start,   // Transfer start pulse
    input  wire logic        row_strobe,   // Row strobe asserted
    input  wire logic        xfer_end,     // Transfer end pulse
    output logic      [18:0] dram_pins,    // Pins A[27:9]
    output logic             col_phase,    // Column mapping on pins
    output logic             page_hit,     // Last start was a hit
    output logic             bank_match    // Last start hit this bank
);
    logic [7:0]  bank_control_reg_ff;
    logic [31:0] bank_mask_reg_ff;
    logic [31:0] bank_base_ff;
    logic [31:0] row_ff;
    logic        row_valid_ff;
    logic [31:0] addr_ff;
    logic [31:0] rdata_ff;
    logic [18:0] pins_ff;
    logic        col_ff;
    logic        hit_ff;
    logic        match_ff;
    logic [18:0] col_pins;
    logic [1:0]  internal_page_size;
    logic [31:0] nxt_cmp_mask;
    drm_pkg::drm_state_t state_ff;

    // Decode page size into the kept address bits above the page offset
    function automatic logic [31:0] page_mask(input logic [1:0] ps);
        // R06 offset width
        if (ps == drm_pkg::PAGE_512)
            page_mask = 32'hffff_fe00;
        else if (ps == drm_pkg::PAGE_1K)
            page_mask = 32'hffff_fc00;
        else
            page_mask = 32'hffff_f800;
    endfunction

    // R04 page size field
    assign internal_page_size = bank_control_reg_ff[drm_pkg::CTRL_PS_LSB +: 2];
    assign nxt_cmp_mask = page_mask(internal_page_size);

    // Register writes; reserved code 3 treated as 2 KByte
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bank_control_reg_ff <= drm_pkg::CTRL_RST;
            bank_mask_reg_ff    <= drm_pkg::MASK_RST;
            bank_base_ff        <= drm_pkg::BASE_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == drm_pkg::OFS_CTRL)
                bank_control_reg_ff <= reg_wdata[7:0];
            else if (reg_addr == drm_pkg::OFS_MASK)
                bank_mask_reg_ff <= reg_wdata;
            else if (reg_addr == drm_pkg::OFS_BASE)
                bank_base_ff <= reg_wdata;
            // Status and unmapped indices are not writable
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= '0;
        else if (reg_rd)
        begin
            if (reg_addr == drm_pkg::OFS_CTRL)
                rdata_ff <= {24'h000000, bank_control_reg_ff};
            else if (reg_addr == drm_pkg::OFS_MASK)
                rdata_ff <= bank_mask_reg_ff;
            else if (reg_addr == drm_pkg::OFS_BASE)
                rdata_ff <= bank_base_ff;
            else if (reg_addr == drm_pkg::OFS_STAT)
                rdata_ff <= {27'h0000000, row_valid_ff, match_ff, hit_ff,
                             state_ff};
            else
                rdata_ff <= '0;
        end
        else
            rdata_ff <= '0;
    end

    // R05 R11 compare stored row above the offset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hit_ff <= 1'b0;
        else if (xfer_start)
            hit_ff <= row_valid_ff &&
                      ((xfer_addr & nxt_cmp_mask) == (row_ff & nxt_cmp_mask));
    end

    // R08 masked bits ignored in bank select
    // Base compared only from the lowest bank select bit upwards
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            match_ff <= 1'b0;
        else if (xfer_start)
            match_ff <= bank_control_reg_ff[drm_pkg::CTRL_EN_BIT] &&
                        (((xfer_addr ^ bank_base_ff) & ~bank_mask_reg_ff)
                         >> drm_pkg::BANK_LSB) == 32'h0;
    end

    // R12 latch row for later compares
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            row_ff       <= '0;
            row_valid_ff <= 1'b0;
        end
        else if (xfer_start)
        begin
            row_ff       <= xfer_addr;
            row_valid_ff <= 1'b1;
        end
        // Any control register write drops the open row; a start in that cycle wins
        else if (reg_wr && reg_addr == drm_pkg::OFS_CTRL)
            row_valid_ff <= 1'b0;
    end

    // R01 R02 R03 R07 R09 column mapping from programmed size
    // Column value follows addr_ff, so it stays fixed for the transfer
    drm_colmap u_colmap (
        .page_size (internal_page_size),
        .addr      (addr_ff),
        .col_pins  (col_pins)
    );

    // R13 phase sequencing: row until strobe, column until end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= drm_pkg::ST_IDLE;
            addr_ff  <= '0;
        end
        else
        begin
            case (state_ff)
                // Start taken only here; a busy start skips the pins
                drm_pkg::ST_IDLE:
                    if (xfer_start)
                    begin
                        addr_ff  <= xfer_addr;
                        state_ff <= drm_pkg::ST_ROW;
                    end
                drm_pkg::ST_ROW:
                    if (xfer_end)
                        state_ff <= drm_pkg::ST_IDLE;
                    else if (row_strobe)
                        state_ff <= drm_pkg::ST_COL;
                drm_pkg::ST_COL:
                    if (xfer_end)
                        state_ff <= drm_pkg::ST_IDLE;
                default:
                    state_ff <= drm_pkg::ST_IDLE;
            endcase
        end
    end

    // Pins: row bits follow A[n]=addr[n]; column picked once row strobed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pins_ff <= '0;
            col_ff  <= 1'b0;
        end
        else if (state_ff == drm_pkg::ST_IDLE && xfer_start)
        begin
            pins_ff <= xfer_addr[27:9];
            col_ff  <= 1'b0;
        end
        else if (state_ff == drm_pkg::ST_ROW && row_strobe && !xfer_end)
        begin
            pins_ff <= col_pins;
            col_ff  <= 1'b1;
        end
        // Pins keep their last value once the transfer ends
        else if (xfer_end)
            col_ff <= 1'b0;
    end

    // Every output comes straight from a flop
    assign reg_rdata  = rdata_ff;
    assign dram_pins  = pins_ff;
    assign col_phase  = col_ff;
    assign page_hit   = hit_ff;
    assign bank_match = match_ff;
endmodule

//--- tb/drm_addr_mux_assertions.sv
// Purpose: Port-level checks on the address multiplexer
// Assumes: One clock, async active-low reset
// Notes:   Busy is mirrored here since state is not on a port
module drm_chk (
    input wire logic        clk,        // Clock
    input wire logic        nrst,       // Reset
    input wire logic [31:0] xfer_addr,  // Address
    input wire logic        xfer_start, // Start
    input wire logic        row_strobe, // Row strobe
    input wire logic        xfer_end,   // End
    input wire logic [18:0] dram_pins,  // Pins
    input wire logic        col_phase,  // Column on
    input wire logic        page_hit,   // Hit
    input wire logic        bank_match  // Match
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        busy_ff; // Transfer in flight
    logic [31:0] last_ff; // Last start address
    // Mirror of busy; a start while busy is refused
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            busy_ff <= 1'b0;
        else if (xfer_end)
            busy_ff <= 1'b0;
        else if (xfer_start)
            busy_ff <= 1'b1;
    // Row latched on every start
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            last_ff <= 32'h0;
        else if (xfer_start)
            last_ff <= xfer_addr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    row_map_a: assert property (xfer_start && !busy_ff |=>
        !col_phase && dram_pins == last_ff[27:9]) else $error("row pins wrong");
    row_wait_a: assert property (busy_ff && !col_phase && !row_strobe && !xfer_end
        |=> !col_phase && $stable(dram_pins)) else $error("row not held");
    col_rise_a: assert property (busy_ff && !col_phase && row_strobe && !xfer_end
        |=> col_phase) else $error("no column phase");
    col_hold_a: assert property (col_phase && !xfer_end
        |=> col_phase && $stable(dram_pins)) else $error("column not held");
    col_end_a: assert property (xfer_end |=> !col_phase) else $error("column stuck");
    pins_keep_a: assert property ($fell(col_phase) |-> $stable(dram_pins))
        else $error("pins moved at end");
    miss_bits_a: assert property (xfer_start && xfer_addr[31:11] != last_ff[31:11]
        |=> !page_hit) else $error("false page hit");
    hit_hold_a: assert property (!xfer_start |=> $stable(page_hit) && $stable(bank_match))
        else $error("hit changed idle");
    cover property (xfer_start ##1 page_hit);
    cover property (xfer_start ##1 bank_match);
    cover property (col_phase && xfer_end);
    cover property (busy_ff && !col_phase && !row_strobe && !xfer_end);
endmodule
bind drm_addr_mux drm_chk u_chk (.clk, .nrst, .xfer_addr, .xfer_start, .row_strobe,
    .xfer_end, .dram_pins, .col_phase, .page_hit, .bank_match);

//--- tb/drm_dram_model.sv
// Purpose: DRAM device seen through the multiplexed pins
// Assumes: Row taken at the row strobe, column while column is on
// Notes:   Captures only; no storage array is modelled
module drm_dram_model (
    input wire logic        clk,        // Clock
    input wire logic        nrst,       // Reset
    input wire logic [18:0] addr_pins,  // A[27:9]
    input wire logic        row_strobe, // Row latch
    input wire logic        col_phase,  // Column latch
    output logic     [18:0] row_q,      // Row captured
    output logic     [18:0] col_q       // Column captured
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latch whatever the pins carry at each strobe
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            {row_q, col_q} <= 38'h0;
        else if (row_strobe && !col_phase)
            row_q <= addr_pins;
        else if (col_phase)
            col_q <= addr_pins;
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the address multiplexer
// Assumes: Bank enable in control bit 2, base and mask at reset zero
// Notes:   Row strobe follows start back to back, except in the slow case
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, reg_wr, reg_rd, xfer_start, row_strobe, xfer_end;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, xfer_addr;
    logic [18:0] dram_pins, row_q, col_q;
    logic        col_phase, page_hit, bank_match;
    int          error_cnt = 0, comparisons = 0, cycles = 0;
    drm_addr_mux uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .xfer_addr, .xfer_start, .row_strobe, .xfer_end, .dram_pins, .col_phase,
        .page_hit, .bank_match);
    drm_dram_model u_mem (.clk, .nrst, .addr_pins(dram_pins), .row_strobe, .col_phase,
        .row_q, .col_q);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Expected column pins, worked out pin by pin
    function automatic logic [18:0] colx(input logic [1:0] ps, input logic [31:0] a);
        int b;
        for (int p = 9; p < 28; p++)
        begin
            b = p & ~1;
            if (ps == 2'h0 && p < 16) b = p - 7;
            if (ps == 2'h1 && p < 18) b = (p == 9) ? 9 : p - 8;
            if (ps == 2'h2 && p < 20) b = (p < 11) ? p : p - 9;
            colx[p-9] = a[b];
        end
    endfunction
    // Whole transfer; every phase is judged on the pins
    task automatic xf(input logic [31:0] a, input logic [1:0] ps, input logic h, input logic m);
        @(posedge clk);
        xfer_addr  <= a;
        xfer_start <= 1'b1;
        @(posedge clk);
        xfer_start <= 1'b0;
        row_strobe <= 1'b1;
        #1 chk({31'h0, page_hit}, {31'h0, h});
        chk({31'h0, bank_match}, {31'h0, m});
        chk({13'h0, dram_pins}, {13'h0, a[27:9]});
        @(posedge clk);
        row_strobe <= 1'b0;
        xfer_end   <= 1'b1;
        #1 chk({12'h0, col_phase, dram_pins}, {13'h1, colx(ps, a)});
        @(posedge clk);
        xfer_end <= 1'b0;
        #1 chk({31'h0, col_phase}, 32'h0);
        chk({13'h0, row_q}, {13'h0, a[27:9]});
        chk({13'h0, col_q}, {13'h0, colx(ps, a)});
    endtask
    task automatic t_regs();
        rd(drm_pkg::OFS_CTRL, {24'h0, drm_pkg::CTRL_RST});
        rd(drm_pkg::OFS_MASK, drm_pkg::MASK_RST);
        rd(drm_pkg::OFS_BASE, drm_pkg::BASE_RST);
        rd(4'h9, 32'h0);
        wr(drm_pkg::OFS_CTRL, 32'hffff_fffe);
        rd(drm_pkg::OFS_CTRL, 32'h0000_00fe);
        wr(drm_pkg::OFS_STAT, 32'hffff_ffff);
        rd(drm_pkg::OFS_STAT, 32'h0);
    endtask
    task automatic t_pages();
        for (int ps = 0; ps < 3; ps++)
        begin
            wr(drm_pkg::OFS_CTRL, {30'h1, 2'(ps)});
            xf(32'h0a5c_3e6c, 2'(ps), 1'b0, 1'b0);
            xf(32'hf5a3_c193, 2'(ps), 1'b0, 1'b0);
            xf(32'h0001_5b34, 2'(ps), 1'b0, 1'b1);
            xf(32'h0001_5b34 ^ (32'h100 << ps), 2'(ps), 1'b1, 1'b1);
            xf(32'h0001_5b34 ^ (32'h300 << ps), 2'(ps), 1'b0, 1'b1);
        end
    endtask
    task automatic t_bank();
        wr(drm_pkg::OFS_BASE, 32'h0040_0000);
        wr(drm_pkg::OFS_MASK, 32'h000e_0000);
        xf(32'h0050_0000, 2'h2, 1'b0, 1'b0);
        xf(32'h004e_0000, 2'h2, 1'b0, 1'b1);
        wr(drm_pkg::OFS_MASK, 32'h001e_0000);
        xf(32'h0050_0000, 2'h2, 1'b0, 1'b1);
        xf(32'h0060_0000, 2'h2, 1'b0, 1'b0);
        rd(drm_pkg::OFS_STAT, 32'h0000_0010);
    endtask
    // Strobes held back; pins must hold through both waits
    task automatic t_slow();
        logic [31:0] a;
        a = 32'h0123_4567;
        @(posedge clk);
        xfer_addr  <= a;
        xfer_start <= 1'b1;
        @(posedge clk);
        xfer_start <= 1'b0;
        @(posedge clk);
        row_strobe <= 1'b1;
        #1 chk({13'h0, dram_pins}, {13'h0, a[27:9]});
        @(posedge clk);
        row_strobe <= 1'b0;
        @(posedge clk);
        xfer_end <= 1'b1;
        #1 chk({12'h0, col_phase, dram_pins}, {13'h1, colx(2'h2, a)});
        @(posedge clk);
        xfer_end <= 1'b0;
        #1 chk({31'h0, col_phase}, 32'h0);
    endtask
    initial
    begin
        {nrst, reg_wr, reg_rd, xfer_start, row_strobe, xfer_end} = 6'h0;
        {reg_addr, reg_wdata, xfer_addr} = 68'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_pages();
        t_bank();
        t_slow();
        report_and_stop();
    end
endmodule
